// [shared/aod_pkg.sv]
package aod_pkg;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_AW = 3;

   // register select codes on the processor register port
   localparam logic [2:0] REG_CONTROL = 3'h0;
   localparam logic [2:0] REG_FIRST_ORIGIN = 3'h1;
   localparam logic [2:0] REG_SECOND_ORIGIN = 3'h2;
   localparam logic [2:0] REG_LENGTH = 3'h3;
   localparam logic [2:0] REG_TIME_STAMP = 3'h4;

   // audio_out_control field positions
   localparam int CTL_TRANSMIT_ENABLE = 0;
   localparam int CTL_STAY_AWAKE = 1;
   localparam int CTL_FIRST_DRAIN_IRQ_ENABLE = 2;
   localparam int CTL_SECOND_DRAIN_IRQ_ENABLE = 3;
   localparam int CTL_BANDWIDTH_IRQ_ENABLE = 4;
   localparam int CTL_STARVATION_IRQ_ENABLE = 5;
   localparam int CTL_LITTLE_ENDIAN = 6;
   localparam int CTL_LAYOUT_LO = 7;
   localparam int CTL_LAYOUT_HI = 8;
   localparam int CTL_FIRST_BUFFER_ACK = 9;
   localparam int CTL_SECOND_BUFFER_ACK = 10;
   localparam int CTL_BANDWIDTH_ERROR_ACK = 11;
   localparam int CTL_STARVATION_ACK = 12;
   localparam int CTL_FIRST_BUFFER_CURRENT = 16;
   localparam int CTL_FIRST_BUFFER_DRAINED = 17;
   localparam int CTL_SECOND_BUFFER_DRAINED = 18;
   localparam int CTL_FETCH_BANDWIDTH_ERROR = 19;
   localparam int CTL_STARVATION = 20;
   localparam int CTL_UNIT_RESET = 31;

   // sample_layout_mode encodings
   localparam logic [1:0] MODE_MONO32 = 2'h0;
   localparam logic [1:0] MODE_STEREO32 = 2'h1;
   localparam logic [1:0] MODE_MONO16 = 2'h2;
   localparam logic [1:0] MODE_STEREO16 = 2'h3;

   localparam logic [31:0] ORIGIN_RESET = 32'h0;
   localparam logic [31:0] LENGTH_RESET = 32'h0;
   localparam logic [31:0] WORD_BYTES = 32'h4;
   localparam logic [31:0] ZERO_WORD = 32'h0;
   localparam logic [15:0] ZERO_HALF = 16'h0;

   typedef enum logic {EMIT_IDLE, EMIT_SECOND} aod_emit_type;
endpackage : aod_pkg

// [core/aod_sync.sv]
`timescale 1ns/1ps
module aod_sync (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_async,
   output logic o_sync
);
   logic stage1;

   // stage1 is read by the second flop only
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         stage1 <= 1'h0;
         o_sync <= 1'h0;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule : aod_sync

// [core/aod_fifo.sv]
`timescale 1ns/1ps
module aod_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_clear,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // count is one bit wider than the pointers so a full fifo is told apart from an empty one
   assign o_in_ready = (count < (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_ptr];
   assign push = i_in_valid && o_in_ready;
   assign pop = i_out_ready && o_out_valid;

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst || i_clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : aod_fifo

// [core/aod_top.sv]
`timescale 1ns/1ps
module aod_top
   import aod_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_cpu_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [2:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   output logic o_mem_req,
   output logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_data,
   input wire logic i_sample_due,
   output logic [31:0] o_left_sample,
   output logic [31:0] o_right_sample,
   output logic o_sample_strobe,
   input wire logic [31:0] i_cycle_tally,
   input wire logic i_global_powerdown,
   output logic o_irq,
   output logic o_wake_request
);
   logic soft_rst;
   logic unit_rst;
   logic tx_enable;
   logic stay_awake;
   logic [3:0] irq_en;
   logic little_endian;
   logic [1:0] layout_mode;
   logic [31:0] first_origin;
   logic [31:0] second_origin;
   logic [31:0] length;
   logic [1:0] drained;
   logic bw_err;
   logic starve;
   logic first_cur;
   logic [1:0] full;
   logic [1:0] pending;
   logic fetch_sel;
   logic [31:0] fetch_left;
   logic [31:0] fetch_addr;
   logic [31:0] units_left;
   logic half_sel;
   logic [31:0] held_left;
   logic [31:0] time_stamp;
   aod_emit_type estate;
   aod_emit_type next_estate;
   logic wr_ctl;
   logic [1:0] ack_buf;
   logic ack_bw;
   logic ack_starve;
   logic enable_rise;
   logic active;
   logic due_sync;
   logic due_prev;
   logic due_pulse;
   logic cur_idx;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [31:0] fifo_out_data;
   logic fetch_req;
   logic push;
   logic pop;
   logic load_out;
   logic unit_done;
   logic buffer_done;
   logic starve_evt;
   logic bw_evt;
   logic hold_left;
   logic [31:0] next_left;
   logic [31:0] next_right;
   logic [31:0] remaining;

   function automatic logic [31:0] pick_sample(input logic [31:0] w, input logic hi, input logic le,
                                               input logic is16);
      logic [15:0] h;
      h = hi ? w[31:16] : w[15:0];
      if (is16) begin
         pick_sample = le ? {h, ZERO_HALF} : {h[7:0], h[15:8], ZERO_HALF};
      end else begin
         pick_sample = le ? w : {w[7:0], w[15:8], w[23:16], w[31:24]};
      end
   endfunction : pick_sample

   // words fetched per buffer; length counts mono samples or stereo pairs
   function automatic logic [31:0] word_count(input logic [31:0] len, input logic [1:0] mode);
      case (mode)
         MODE_MONO16: word_count = {1'h0, len[31:1]};
         MODE_STEREO32: word_count = {len[30:0], 1'h0};
         default: word_count = len;
      endcase
   endfunction : word_count

   assign unit_rst = i_rst || soft_rst;
   assign wr_ctl = i_reg_wr && (i_reg_addr == REG_CONTROL);
   assign ack_buf[0] = wr_ctl && i_reg_wdata[CTL_FIRST_BUFFER_ACK];
   assign ack_buf[1] = wr_ctl && i_reg_wdata[CTL_SECOND_BUFFER_ACK];
   assign ack_bw = wr_ctl && i_reg_wdata[CTL_BANDWIDTH_ERROR_ACK];
   assign ack_starve = wr_ctl && i_reg_wdata[CTL_STARVATION_ACK];
   assign enable_rise = wr_ctl && i_reg_wdata[CTL_TRANSMIT_ENABLE] && !tx_enable;
   assign active = tx_enable && (!i_global_powerdown || stay_awake);
   assign cur_idx = !first_cur;
   assign due_pulse = due_sync && !due_prev;

   aod_sync u_due_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(i_sample_due),
      .o_sync(due_sync)
   );

   // fetch side only asks while the fifo has room, so memory can never overrun it
   assign fetch_req = active && (fetch_left != ZERO_WORD) && fifo_in_ready;
   assign push = fetch_req && i_mem_ack;
   assign o_mem_req = fetch_req;

   aod_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_rst(unit_rst),
      .i_clear(!tx_enable),
      .i_in_valid(push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_mem_data),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(pop),
      .o_out_data(fifo_out_data)
   );

   assign remaining = (units_left == ZERO_WORD) ? length : units_left;

   // emission: on a missing sample nothing loads, so the last output repeats
   always_comb begin
      next_estate = estate;
      pop = 1'h0;
      load_out = 1'h0;
      unit_done = 1'h0;
      starve_evt = 1'h0;
      bw_evt = 1'h0;
      hold_left = 1'h0;
      next_left = o_left_sample;
      next_right = o_right_sample;
      case (estate)
         EMIT_IDLE: begin
            if (due_pulse && active) begin
               if (!full[cur_idx]) begin
                  starve_evt = 1'h1;
               end else if (!fifo_out_valid) begin
                  bw_evt = 1'h1;
               end else begin
                  pop = (layout_mode != MODE_MONO16) || half_sel;
                  case (layout_mode)
                     MODE_STEREO32: begin
                        hold_left = 1'h1;
                        next_estate = EMIT_SECOND;
                     end
                     MODE_STEREO16: begin
                        next_left = pick_sample(fifo_out_data, 1'h0, little_endian, 1'h1);
                        next_right = pick_sample(fifo_out_data, 1'h1, little_endian, 1'h1);
                        load_out = 1'h1;
                        unit_done = 1'h1;
                     end
                     MODE_MONO16: begin
                        next_left = pick_sample(fifo_out_data, half_sel, little_endian, 1'h1);
                        next_right = next_left;
                        load_out = 1'h1;
                        unit_done = 1'h1;
                     end
                     default: begin
                        next_left = pick_sample(fifo_out_data, 1'h0, little_endian, 1'h0);
                        next_right = next_left;
                        load_out = 1'h1;
                        unit_done = 1'h1;
                     end
                  endcase
               end
            end
         end
         EMIT_SECOND: begin
            next_estate = EMIT_IDLE;
            if (fifo_out_valid) begin
               pop = 1'h1;
               next_left = held_left;
               next_right = pick_sample(fifo_out_data, 1'h0, little_endian, 1'h0);
               load_out = 1'h1;
               unit_done = 1'h1;
            end else begin
               bw_evt = 1'h1;
            end
         end
         default: next_estate = EMIT_IDLE;
      endcase
   end

   assign buffer_done = unit_done && (remaining <= 32'h1);

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         soft_rst <= 1'h0;
         due_prev <= 1'h0;
      end else begin
         soft_rst <= wr_ctl && i_reg_wdata[CTL_UNIT_RESET];
         due_prev <= due_sync;
      end
   end

   // software-written control and buffer description
   always_ff @(posedge i_core_clk) begin
      if (unit_rst) begin
         tx_enable <= 1'h0;
         stay_awake <= 1'h0;
         irq_en <= 4'h0;
         little_endian <= 1'h0;
         layout_mode <= MODE_MONO32;
         first_origin <= ORIGIN_RESET;
         second_origin <= ORIGIN_RESET;
         length <= LENGTH_RESET;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            REG_CONTROL: begin
               tx_enable <= i_reg_wdata[CTL_TRANSMIT_ENABLE];
               stay_awake <= i_reg_wdata[CTL_STAY_AWAKE];
               irq_en <= i_reg_wdata[CTL_STARVATION_IRQ_ENABLE:CTL_FIRST_DRAIN_IRQ_ENABLE];
               little_endian <= i_reg_wdata[CTL_LITTLE_ENDIAN];
               layout_mode <= i_reg_wdata[CTL_LAYOUT_HI:CTL_LAYOUT_LO];
            end
            REG_FIRST_ORIGIN: first_origin <= i_reg_wdata;
            REG_SECOND_ORIGIN: second_origin <= i_reg_wdata;
            REG_LENGTH: length <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // buffer bookkeeping; in drained a hardware set beats a same-cycle ack, in full and pending the ack beats the hardware clear
   always_ff @(posedge i_core_clk) begin
      if (unit_rst) begin
         first_cur <= 1'h1;
         full <= 2'h0;
         pending <= 2'h0;
         drained <= 2'h0;
         units_left <= ZERO_WORD;
         half_sel <= 1'h0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (enable_rise || ack_buf[b]) begin
               full[b] <= 1'h1;
            end else if (buffer_done && (cur_idx == b[0])) begin
               full[b] <= 1'h0;
            end
            if (enable_rise || ack_buf[b]) begin
               pending[b] <= 1'h1;
            end else if (active && (fetch_left == ZERO_WORD) && (fetch_sel == b[0])) begin
               pending[b] <= 1'h0;
            end
            if (buffer_done && (cur_idx == b[0])) begin
               drained[b] <= 1'h1;
            end else if (ack_buf[b]) begin
               drained[b] <= 1'h0;
            end
         end
         if (enable_rise) begin
            units_left <= ZERO_WORD;
            half_sel <= 1'h0;
         end else if (unit_done) begin
            units_left <= remaining - 32'h1;
            half_sel <= (layout_mode == MODE_MONO16) && !half_sel;
         end
         if (buffer_done) begin
            first_cur <= !first_cur;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (unit_rst) begin
         bw_err <= 1'h0;
         starve <= 1'h0;
      end else begin
         if (bw_evt) begin
            bw_err <= 1'h1;
         end else if (ack_bw) begin
            bw_err <= 1'h0;
         end
         if (starve_evt) begin
            starve <= 1'h1;
         end else if (ack_starve) begin
            starve <= 1'h0;
         end
      end
   end

   // fetch pointer walks one buffer at a time, ahead of emission
   always_ff @(posedge i_core_clk) begin
      if (unit_rst || !tx_enable || enable_rise) begin
         fetch_sel <= cur_idx;
         fetch_left <= ZERO_WORD;
         fetch_addr <= ZERO_WORD;
      end else if (active && (fetch_left == ZERO_WORD) && pending[fetch_sel]) begin
         fetch_addr <= fetch_sel ? second_origin : first_origin;
         fetch_left <= word_count(length, layout_mode);
      end else if (push) begin
         fetch_addr <= fetch_addr + WORD_BYTES;
         fetch_left <= fetch_left - 32'h1;
         if (fetch_left == 32'h1) begin
            fetch_sel <= !fetch_sel;
         end
      end
   end
   assign o_mem_addr = fetch_addr;

   always_ff @(posedge i_core_clk) begin
      if (unit_rst || !tx_enable) begin
         estate <= EMIT_IDLE;
         held_left <= ZERO_WORD;
         o_left_sample <= ZERO_WORD;
         o_right_sample <= ZERO_WORD;
         o_sample_strobe <= 1'h0;
      end else begin
         estate <= next_estate;
         o_sample_strobe <= load_out;
         if (hold_left) begin
            held_left <= pick_sample(fifo_out_data, 1'h0, little_endian, 1'h0);
         end
         if (load_out) begin
            o_left_sample <= next_left;
            o_right_sample <= next_right;
         end
      end
   end

   // time stamp survives a unit reset so it stays aligned with the tally
   always_ff @(posedge i_core_clk) begin
      if (i_rst || i_cpu_rst) begin
         time_stamp <= ZERO_WORD;
      end else if (buffer_done) begin
         time_stamp <= i_cycle_tally;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (unit_rst) begin
         o_irq <= 1'h0;
         o_wake_request <= 1'h0;
      end else begin
         o_irq <= |({starve, bw_err, drained} & irq_en);
         o_wake_request <= (|({starve, bw_err, drained} & irq_en)) && stay_awake && i_global_powerdown;
      end
   end

   // acks and the reset bit are not stored, so they read back as zero
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_reg_rdata <= ZERO_WORD;
      end else if (i_reg_rd) begin
         o_reg_rdata <= ZERO_WORD;
         case (i_reg_addr)
            REG_CONTROL: begin
               o_reg_rdata[CTL_TRANSMIT_ENABLE] <= tx_enable;
               o_reg_rdata[CTL_STAY_AWAKE] <= stay_awake;
               o_reg_rdata[CTL_STARVATION_IRQ_ENABLE:CTL_FIRST_DRAIN_IRQ_ENABLE] <= irq_en;
               o_reg_rdata[CTL_LITTLE_ENDIAN] <= little_endian;
               o_reg_rdata[CTL_LAYOUT_HI:CTL_LAYOUT_LO] <= layout_mode;
               o_reg_rdata[CTL_FIRST_BUFFER_CURRENT] <= first_cur;
               o_reg_rdata[CTL_FIRST_BUFFER_DRAINED] <= drained[0];
               o_reg_rdata[CTL_SECOND_BUFFER_DRAINED] <= drained[1];
               o_reg_rdata[CTL_FETCH_BANDWIDTH_ERROR] <= bw_err;
               o_reg_rdata[CTL_STARVATION] <= starve;
            end
            REG_FIRST_ORIGIN: o_reg_rdata <= first_origin;
            REG_SECOND_ORIGIN: o_reg_rdata <= second_origin;
            REG_LENGTH: o_reg_rdata <= length;
            REG_TIME_STAMP: o_reg_rdata <= time_stamp;
            default: o_reg_rdata <= ZERO_WORD;
         endcase
      end
   end
endmodule : aod_top

// [test/aod_properties.sv]
`timescale 1ns/1ps
module aod_properties
   import aod_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [2:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [31:0] o_reg_rdata,
   input wire logic o_mem_req,
   input wire logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [31:0] o_left_sample,
   input wire logic o_sample_strobe,
   input wire logic i_global_powerdown,
   input wire logic o_irq,
   input wire logic o_wake_request
);
   logic awake;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_ctl_wr;
      i_reg_wr && i_reg_addr == REG_CONTROL;
   endsequence
   sequence s_unit_rst;
      s_ctl_wr ##0 i_reg_wdata[CTL_UNIT_RESET];
   endsequence
   sequence s_plain_wr;
      s_ctl_wr ##0 !i_reg_wdata[CTL_UNIT_RESET];
   endsequence
   // mirror of stay_awake; cleared at the reset write, a little ahead of the block
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         awake <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == REG_CONTROL) begin
         awake <= i_reg_wdata[CTL_STAY_AWAKE] && !i_reg_wdata[CTL_UNIT_RESET];
      end
   end
   AST_RESET_QUIET: assert property (disable iff (1'b0) i_rst |=> !o_irq && !o_mem_req && !o_sample_strobe)
      else $error("outputs active after reset");
   AST_UNIT_RESET: assert property (s_unit_rst |=> ##3 !o_irq && !o_mem_req && o_left_sample == ZERO_WORD)
      else $error("unit reset left state behind");
   AST_IRQ_MASKED: assert property (s_plain_wr ##0 i_reg_wdata[5:2] == 4'h0 |=> ##1 !o_irq)
      else $error("irq without enable");
   AST_IDLE_NO_FETCH: assert property (s_plain_wr ##0 !i_reg_wdata[CTL_TRANSMIT_ENABLE] |=> !o_mem_req)
      else $error("fetch while transmit off");
   AST_ACK_READS_ZERO: assert property (i_reg_rd && i_reg_addr == REG_CONTROL |=> o_reg_rdata[12:9] == 4'h0 && !o_reg_rdata[31])
      else $error("ack bits read nonzero");
   AST_STROBE_PULSE: assert property (o_sample_strobe |=> !o_sample_strobe)
      else $error("strobe longer than one cycle");
   AST_FETCH_HOLD: assert property (o_mem_req && !i_mem_ack ##1 o_mem_req |-> $stable(o_mem_addr))
      else $error("fetch address moved before ack");
   AST_SLEEP_NO_FETCH: assert property (i_global_powerdown && !awake |-> !o_mem_req)
      else $error("fetch during powerdown");
   AST_WAKE_CAUSE: assert property (o_wake_request |-> o_irq && $past(awake) && $past(i_global_powerdown))
      else $error("wake without cause");
endmodule : aod_properties

bind aod_top aod_properties u_props (.i_core_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
   .o_reg_rdata, .o_mem_req, .o_mem_addr, .i_mem_ack, .o_left_sample, .o_sample_strobe, .i_global_powerdown,
   .o_irq, .o_wake_request);

// [test/aod_mem_model.sv]
`timescale 1ns/1ps
module aod_mem_model (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_stall,
   input wire logic i_req,
   input wire logic [31:0] i_addr,
   output logic o_ack,
   output logic [31:0] o_data
);
   // every byte holds the low byte of its own address, so order slips show up
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         o_data <= 32'h0;
      end else if (i_stall || o_ack || !i_req) begin
         o_ack <= 1'b0;
         o_data <= ~o_data;
      end else begin
         o_ack <= 1'b1;
         o_data <= {i_addr[7:0] + 8'h3, i_addr[7:0] + 8'h2, i_addr[7:0] + 8'h1, i_addr[7:0]};
      end
   end
endmodule : aod_mem_model

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top
   import aod_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cpu_rst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic due = 1'b0;
   logic pd = 1'b0;
   logic stall = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] tally = 32'h1000;
   logic [31:0] tseen = 32'h0;
   logic [31:0] rdata, maddr, mdata, left, right;
   logic mreq, mack, strobe, irq, wake;
   int fails = 0;
   int total_checks = 0;

   always #2.5 clk = ~clk;
   always @(posedge clk) tally <= tally + 32'h1;

   aod_mem_model mem (.i_core_clk(clk), .i_rst(rst), .i_stall(stall), .i_req(mreq), .i_addr(maddr),
      .o_ack(mack), .o_data(mdata));
   aod_top dut (.i_core_clk(clk), .i_rst(rst), .i_cpu_rst(cpu_rst), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_mem_req(mreq), .o_mem_addr(maddr),
      .i_mem_ack(mack), .i_mem_data(mdata), .i_sample_due(due), .o_left_sample(left), .o_right_sample(right),
      .o_sample_strobe(strobe), .i_cycle_tally(tally), .i_global_powerdown(pd), .o_irq(irq),
      .o_wake_request(wake));

   function automatic logic [31:0] s32(input logic [7:0] b, input bit le);
      return le ? {b + 8'h3, b + 8'h2, b + 8'h1, b} : {b, b + 8'h1, b + 8'h2, b + 8'h3};
   endfunction : s32
   function automatic logic [31:0] s16(input logic [7:0] b, input bit le);
      return le ? {b + 8'h1, b, ZERO_HALF} : {b, b + 8'h1, ZERO_HALF};
   endfunction : s16

   task automatic print_verdict();
      if (fails == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk) wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk) wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [31:0] d);
      @(posedge clk) rd <= 1'b1;
      addr <= a;
      @(posedge clk) rd <= 1'b0;
      @(posedge clk) d = rdata;
   endtask : rd_reg
   task automatic rc(input logic [2:0] a, input logic [31:0] e, input string nm);
      logic [31:0] v;
      rd_reg(a, v);
      chk(nm, e, v);
   endtask : rc
   task automatic cfg(input logic [31:0] ctl);
      wr_reg(REG_FIRST_ORIGIN, 32'h40);
      wr_reg(REG_SECOND_ORIGIN, 32'h80);
      wr_reg(REG_LENGTH, 32'h40);
      wr_reg(REG_CONTROL, ctl);
      repeat (8) @(posedge clk);
   endtask : cfg
   task automatic unit_reset();
      wr_reg(REG_CONTROL, 32'h8000_0000);
      repeat (3) @(posedge clk);
   endtask : unit_reset
   // due edges stay 18 cycles apart, well over the minimum spacing
   task automatic pulse(output bit got);
      got = 0;
      @(posedge clk) due <= 1'b1;
      for (int k = 0; k < 12; k++) begin
         @(posedge clk);
         #1;
         if (strobe === 1'b1 && !got) begin
            got = 1;
            tseen = tally;
         end
      end
      @(posedge clk) due <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse
   task automatic stream(input logic [1:0] m, input bit le, input logic [7:0] b, input int cnt);
      bit got;
      logic [7:0] a;
      logic [31:0] l, r;
      for (int n = 0; n < cnt; n++) begin
         pulse(got);
         chk("sample_strobe", 32'h1, {31'h0, got});
         if (!got) print_verdict();
         a = b + 8'(n * (m == MODE_STEREO32 ? 8 : (m == MODE_MONO16 ? 2 : 4)));
         l = m[1] ? s16(a, le) : s32(a, le);
         r = (m == MODE_MONO32) ? l : (m[1] ? s16(a + 8'h2, le) : s32(a + 8'h4, le));
         chk("left_sample", l, left);
         if (m != MODE_MONO16) chk("right_sample", r, right);
      end
   endtask : stream

   task automatic t_defaults();
      rc(REG_CONTROL, 32'h0001_0000, "control");
      rc(REG_FIRST_ORIGIN, ORIGIN_RESET, "first_origin");
      rc(REG_LENGTH, LENGTH_RESET, "length");
      rc(REG_TIME_STAMP, 32'h0, "time_stamp");
      wr_reg(REG_SECOND_ORIGIN, 32'hFFFF_FFC0);
      rc(REG_SECOND_ORIGIN, 32'hFFFF_FFC0, "second_origin");
      wr_reg(3'h5, 32'hFFFF_FFFF);
      rc(3'h5, 32'h0, "unmapped");
      wr_reg(REG_TIME_STAMP, 32'hFFFF_FFFF);
      rc(REG_TIME_STAMP, 32'h0, "time_stamp_ro");
   endtask : t_defaults
   task automatic t_pingpong();
      logic [31:0] v;
      cfg(32'h5);
      stream(MODE_MONO32, 1'b0, 8'h40, 64);
      rd_reg(REG_TIME_STAMP, v);
      chk("time_stamp_window", 32'h1, {31'h0, v <= tseen && v + 32'h3 >= tseen});
      chk("irq_first_drained", 32'h1, {31'h0, irq});
      rc(REG_CONTROL, 32'h0002_0005, "control_first_drained");
      wr_reg(REG_CONTROL, 32'h0205);
      rc(REG_CONTROL, 32'h0000_0005, "control_first_ack");
      chk("irq_after_ack", 32'h0, {31'h0, irq});
      stream(MODE_MONO32, 1'b0, 8'h80, 64);
      rc(REG_CONTROL, 32'h0005_0005, "control_second_drained");
      stream(MODE_MONO32, 1'b0, 8'h40, 64);
   endtask : t_pingpong
   task automatic t_starve();
      bit got;
      logic [31:0] v;
      pulse(got);
      chk("repeat_left", s32(8'h3C, 1'b0), left);
      wr_reg(REG_CONTROL, 32'h0421);
      rd_reg(REG_CONTROL, v);
      chk("starvation_kept", 32'h1, {31'h0, v[CTL_STARVATION]});
      chk("irq_starvation", 32'h1, {31'h0, irq});
      wr_reg(REG_CONTROL, 32'h0023);
      pd <= 1'b1;
      repeat (3) @(posedge clk);
      chk("wake_request", 32'h1, {31'h0, wake});
      @(posedge clk) pd <= 1'b0;
      wr_reg(REG_CONTROL, 32'h1021);
      rd_reg(REG_CONTROL, v);
      chk("starvation_acked", 32'h0, {31'h0, v[CTL_STARVATION]});
      chk("irq_starvation_acked", 32'h0, {31'h0, irq});
   endtask : t_starve
   task automatic t_bandwidth();
      bit got;
      logic [31:0] v, ts;
      rd_reg(REG_TIME_STAMP, ts);
      unit_reset();
      rc(REG_CONTROL, 32'h0001_0000, "control_unit_reset");
      rc(REG_LENGTH, LENGTH_RESET, "length_unit_reset");
      rc(REG_TIME_STAMP, ts, "time_stamp_kept");
      stall <= 1'b1;
      cfg(32'h11);
      chk("mem_req_stalled", 32'h1, {31'h0, mreq});
      pd <= 1'b1;
      repeat (2) @(posedge clk);
      chk("mem_req_powerdown", 32'h0, {31'h0, mreq});
      pd <= 1'b0;
      pulse(got);
      @(posedge clk) stall <= 1'b0;
      repeat (20) @(posedge clk);
      rd_reg(REG_CONTROL, v);
      chk("bandwidth_sticky", 32'h1, {31'h0, v[CTL_FETCH_BANDWIDTH_ERROR]});
      chk("irq_bandwidth", 32'h1, {31'h0, irq});
      wr_reg(REG_CONTROL, 32'h0);
      wr_reg(REG_CONTROL, 32'h0800);
      rd_reg(REG_CONTROL, v);
      chk("bandwidth_acked", 32'h0, {31'h0, v[CTL_FETCH_BANDWIDTH_ERROR]});
      cpu_rst <= 1'b1;
      @(posedge clk) cpu_rst <= 1'b0;
      rc(REG_TIME_STAMP, 32'h0, "time_stamp_cpu_reset");
      rc(REG_LENGTH, 32'h40, "length_cpu_reset");
   endtask : t_bandwidth
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         unit_reset();
         cfg({23'h0, 2'(m), m[0], 6'h01});
         stream(2'(m), m[0], 8'h40, 6);
      end
   endtask : t_modes

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_pingpong();
      t_starve();
      t_bandwidth();
      t_modes();
      print_verdict();
   end
endmodule : tb_top
